// >>> src/digital_input_port_read.v
// Read command interpreter for the 8-bit isolated digital input port
`timescale 1ns/100ps
`include "dio_read_map.vh"
// Function
// - Each slot has an 8-bit input port, each bit independent.
// - Closed switch reads as 1, open switch reads as 0.
// - Slot word read samples eight bits, replies decimal 0 to 255.
// - Reply equals sum of set-bit weights, bit n weighs two to n.
// - Bit address is slot tens digit plus bit units digit.
// - Units digit 8 or 9 is rejected; host must not send them.
// - Set bit replies +1.000E+0, clear bit replies +0.000E+0.
// - Comma list of bit addresses gives one value each, in order.
// - An input event can trigger a voltmeter conversion.
module digital_input_port_read (
	input wire i_sys_clk,
	input wire i_arst_n,
	input wire [23:0] i_port_in,
	input wire [2:0] i_event_enable,
	input wire i_cmd_valid,
	input wire [1:0] i_cmd_kind,
	input wire [1:0] i_cmd_slot,
	input wire [3:0] i_list_len,
	input wire [63:0] i_list_addr,
	output wire o_cmd_ready,
	output reg o_char_valid,
	output reg [7:0] o_char,
	input wire i_char_ready,
	output reg o_addr_error,
	output reg o_reply_done,
	output reg o_trigger
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WORD = 2'h1;
	localparam ST_BITS = 2'h2;
	reg [1:0] state;
	reg [1:0] next_state;
	reg [7:0] snap [0:2];
	reg [23:0] prev_in;
	reg [7:0] word;
	reg [63:0] list;
	reg [3:0] list_left;
	reg [3:0] char_idx;
	reg [1:0] digit_idx;
	wire [7:0] addr_cur = list[7:0];
	wire [3:0] tens = addr_cur[7:4];
	wire [3:0] units = addr_cur[3:0];
	wire [1:0] slot_sel = tens[1:0];
	wire bit_val = snap[slot_sel][units[2:0]];
	wire [7:0] bit_char;
	reg [7:0] hund;
	reg [7:0] ten_d;
	reg [7:0] one_d;
	wire take;
	wire eol_taken;
	wire bad;
	reg [7:0] word_char;
	reg [7:0] slot_word;
	wire [`LIST_MAX-1:0] entry_bad;
	wire [`SLOT_COUNT-1:0] slot_rise;
	genvar g;
	assign o_cmd_ready = (state == ST_IDLE);
	assign take = o_cmd_ready && i_cmd_valid;
	// The closing end-of-line leaving the port ends every reply
	assign eol_taken = i_char_ready && o_char_valid && o_char == `CHAR_EOL;
	assign bad = |entry_bad;
	// Decimal digits of the sampled word, hundreds first
	always @* begin
		if (word >= 8'hc8)
			hund = 8'h02;
		else if (word >= 8'h64)
			hund = 8'h01;
		else
			hund = 8'h00;
		ten_d = (word - hund * 8'h64) / 8'h0a;
		one_d = word - hund * 8'h64 - ten_d * 8'h0a;
	end
	// Word reply: three digits, then end of line
	always @* begin
		case (digit_idx)
		2'h0: word_char = `CHAR_ZERO + hund;
		2'h1: word_char = `CHAR_ZERO + ten_d;
		2'h2: word_char = `CHAR_ZERO + one_d;
		default: word_char = `CHAR_EOL;
		endcase
	end
	// Slot numbers above two read as an empty port
	always @* begin
		case (i_cmd_slot)
		2'h0: slot_word = i_port_in[7:0];
		2'h1: slot_word = i_port_in[15:8];
		2'h2: slot_word = i_port_in[23:16];
		default: slot_word = 8'h00;
		endcase
	end
	// Per-entry address check and per-slot event detect
	generate
		for (g = 0; g < `LIST_MAX; g = g + 1) begin : g_entry
			// Entries beyond the list length are ignored
			wire [3:0] e_units = i_list_addr[g*8+:4];
			wire [3:0] e_tens = i_list_addr[g*8+4+:4];
			assign entry_bad[g] = (g < i_list_len) &&
			    (e_units > `ADDR_MAX_UNITS || e_tens > `SLOT_MAX_TENS);
		end
		for (g = 0; g < `SLOT_COUNT; g = g + 1) begin : g_slot
			// A bit going from open to closed counts as an event
			assign slot_rise[g] = i_event_enable[g] &&
			    |(i_port_in[g*8+:8] & ~prev_in[g*8+:8]);
		end
	endgenerate
	bit_text_encoder u_enc (
		.i_bit(bit_val),
		.i_index(char_idx),
		.o_char(bit_char)
	);
	// Idle takes a command; a bad bit list leaves the block idle
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE:
			if (take && i_cmd_kind == `CMD_READ_SLOT_WORD)
				next_state = ST_WORD;
			else if (take && i_cmd_kind == `CMD_READ_SINGLE_BIT &&
			    !bad && i_list_len != 4'h0)
				next_state = ST_BITS;
		ST_WORD:
			if (eol_taken)
				next_state = ST_IDLE;
		ST_BITS:
			if (eol_taken)
				next_state = ST_IDLE;
		default: next_state = ST_IDLE;
		endcase
	end
	// Fresh sample of every slot at command time, ones mean closed
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			snap[0] <= 8'h00;
			snap[1] <= 8'h00;
			snap[2] <= 8'h00;
		end else if (take) begin
			snap[0] <= i_port_in[7:0];
			snap[1] <= i_port_in[15:8];
			snap[2] <= i_port_in[23:16];
		end
	end
	// Event trigger runs beside the command path
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prev_in <= 24'h000000;
			o_trigger <= 1'b0;
		end else begin
			prev_in <= i_port_in;
			o_trigger <= |slot_rise;
		end
	end
	// Reply characters stand until the host takes them
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= ST_IDLE;
			word <= 8'h00;
			list <= 64'h0;
			list_left <= 4'h0;
			char_idx <= 4'h0;
			digit_idx <= 2'h0;
			o_char_valid <= 1'b0;
			o_char <= 8'h00;
			o_addr_error <= 1'b0;
			o_reply_done <= 1'b0;
		end else begin
			state <= next_state;
			o_addr_error <= 1'b0;
			o_reply_done <= 1'b0;
			if (take) begin
				if (i_cmd_kind == `CMD_READ_SLOT_WORD) begin
					// Weighted sum is the binary word itself
					word <= slot_word;
					digit_idx <= 2'h0;
					o_char_valid <= 1'b0;
				end else if (i_cmd_kind == `CMD_READ_SINGLE_BIT) begin
					o_addr_error <= bad | (i_list_len == 4'h0);
					list <= i_list_addr;
					list_left <= i_list_len;
					char_idx <= 4'h0;
				end
			end else if (state == ST_WORD) begin
				if (eol_taken) begin
					o_char_valid <= 1'b0;
					o_reply_done <= 1'b1;
				end else if (!o_char_valid || i_char_ready) begin
					o_char_valid <= 1'b1;
					o_char <= word_char;
					digit_idx <= digit_idx + 2'h1;
				end
			end else if (state == ST_BITS) begin
				if (eol_taken) begin
					o_char_valid <= 1'b0;
					o_reply_done <= 1'b1;
				end else if (!o_char_valid || i_char_ready) begin
					o_char_valid <= 1'b1;
					// Nine characters per value, then a separator
					if (char_idx == 4'h9) begin
						// Values follow list order, separated by commas
						char_idx <= 4'h0;
						list <= {8'h00, list[63:8]};
						list_left <= list_left - 4'h1;
						if (list_left == 4'h1)
							o_char <= `CHAR_EOL;
						else
							o_char <= `CHAR_COMMA;
					end else begin
						o_char <= bit_char;
						char_idx <= char_idx + 4'h1;
					end
				end
			end else begin
				o_char_valid <= 1'b0;
			end
		end
	end
endmodule // digital_input_port_read

// >>> src/dio_read_map.vh
// Constants for the digital input port read command interpreter
`ifndef DIO_READ_MAP_VH
`define DIO_READ_MAP_VH
`define SLOT_COUNT 3
`define PORT_WIDTH 8
`define ADDR_MAX_UNITS 4'h7
`define SLOT_MAX_TENS 4'h2
`define CMD_READ_SLOT_WORD 2'h1
`define CMD_READ_SINGLE_BIT 2'h2
`define LIST_MAX 8
`define REPLY_ONE 8'h31
`define REPLY_ZERO 8'h30
`define CHAR_PLUS 8'h2b
`define CHAR_DOT 8'h2e
`define CHAR_E 8'h45
`define CHAR_ZERO 8'h30
`define CHAR_COMMA 8'h2c
`define CHAR_EOL 8'h0a
`endif

// >>> src/bit_text_encoder.v
// Formats one bit as the text +1.000E+0 or +0.000E+0
`timescale 1ns/100ps
`include "dio_read_map.vh"
module bit_text_encoder (
	input wire i_bit,
	input wire [3:0] i_index,
	output reg [7:0] o_char
);
	always @* begin
		case (i_index)
		4'h0: o_char = `CHAR_PLUS;
		4'h1: o_char = i_bit ? `REPLY_ONE : `REPLY_ZERO;
		4'h2: o_char = `CHAR_DOT;
		4'h3: o_char = `CHAR_ZERO;
		4'h4: o_char = `CHAR_ZERO;
		4'h5: o_char = `CHAR_ZERO;
		4'h6: o_char = `CHAR_E;
		4'h7: o_char = `CHAR_PLUS;
		4'h8: o_char = `CHAR_ZERO;
		default: o_char = `CHAR_ZERO;
		endcase
	end
endmodule // bit_text_encoder

// >>> verif/dio_read_sva.sv
// Assertions on the digital input port read interpreter
`timescale 1ns/100ps
`include "dio_read_map.vh"
module dio_read_sva (
	input wire i_sys_clk,
	input wire i_arst_n,
	input wire [2:0] i_event_enable,
	input wire i_cmd_valid,
	input wire [1:0] i_cmd_kind,
	input wire o_cmd_ready,
	input wire o_char_valid,
	input wire [7:0] o_char,
	input wire i_char_ready,
	input wire o_addr_error,
	input wire o_reply_done,
	input wire o_trigger
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	wire take = i_cmd_valid && o_cmd_ready;
	char_hold_a: assert property (o_char_valid && !i_char_ready |=>
		o_char_valid && $stable(o_char)) else $error("char changed");
	word_start_a: assert property (take && i_cmd_kind == 2'h1 |->
		##2 o_char_valid && o_char < 8'h33) else $error("word late");
	bit_start_a: assert property (take && i_cmd_kind == 2'h2 |->
		##[1:2] (o_addr_error || o_char == 8'h2b)) else $error("bit late");
	err_idle_a: assert property (o_addr_error |->
		o_cmd_ready && !o_char_valid ##1 !o_addr_error) else $error("err");
	done_eol_a: assert property (o_reply_done |-> $past(o_char) == 8'h0a
		&& $past(i_char_ready) && o_cmd_ready) else $error("done early");
	busy_a: assert property (o_char_valid |-> !o_cmd_ready)
		else $error("ready while busy");
	trig_off_a: assert property ((i_event_enable == 3'h0) [*3] |->
		!o_trigger) else $error("trigger while disabled");
	done_pulse_a: assert property (o_reply_done |=> !o_reply_done)
		else $error("done too long");
	word_c: cover property (take && i_cmd_kind == 2'h1);
	err_c: cover property (o_addr_error);
	trig_c: cover property (o_trigger);
endmodule // dio_read_sva
bind digital_input_port_read dio_read_sva chk_u (.*);

// >>> verif/char_sink.sv
// Host side that takes reply characters, fast or with stalls
`timescale 1ns/100ps
module char_sink (
	input wire i_sys_clk,
	input wire i_slow,
	input wire i_char_valid,
	input wire [7:0] i_char,
	output reg o_char_ready = 1'b0
);
	string text = "";
	always @(posedge i_sys_clk) if (i_char_valid && o_char_ready) begin
		text = {text, $sformatf("%c", i_char)};
	end
	always @(negedge i_sys_clk) o_char_ready <= !i_slow || !o_char_ready;
endmodule // char_sink

// >>> verif/digital_input_port_read_tb.sv
// Bench for the digital input port read interpreter
`timescale 1ns/100ps
module digital_input_port_read_tb;
	reg clk = 0, rst_n = 0, vld = 0, slow = 0, saw = 0;
	reg [23:0] pin = 0;
	reg [2:0] ev = 0;
	reg [1:0] kind = 0, slot = 0;
	reg [3:0] len = 0;
	reg [63:0] adr = 0;
	wire rdy, cv, crd, err, done, trig;
	wire [7:0] ch;
	int errors = 0, checked = 0, cyc = 0, t;
	digital_input_port_read dut_u (.i_sys_clk(clk), .i_arst_n(rst_n),
		.i_port_in(pin), .i_event_enable(ev), .i_cmd_valid(vld),
		.i_cmd_kind(kind), .i_cmd_slot(slot), .i_list_len(len),
		.i_list_addr(adr), .o_cmd_ready(rdy), .o_char_valid(cv),
		.o_char(ch), .i_char_ready(crd), .o_addr_error(err),
		.o_reply_done(done), .o_trigger(trig));
	char_sink host_u (.i_sys_clk(clk), .i_slow(slow), .i_char_valid(cv),
		.i_char(ch), .o_char_ready(crd));
	always #4 clk = ~clk;
	always @(posedge clk) begin
		saw <= saw | trig;
		if (++cyc == 3000) begin
			errors++;
			give_verdict;
		end
	end
	task give_verdict;
		if (errors == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk_s(input string g, e);
		checked++;
		if (g != e) begin
			errors++;
			$display("wrong value at %0t: %s", $time, g);
		end
	endtask
	task chk_b(input logic g);
		checked++;
		if (g !== 1'b1) begin
			errors++;
			$display("wrong value at %0t: flag low", $time);
		end
	endtask
	task run(input [1:0] k, s, input [3:0] n, input [63:0] a);
		host_u.text = "";
		@(negedge clk);
		{vld, kind, slot, len, adr} = {1'b1, k, s, n, a};
		@(negedge clk);
		vld = 0;
		for (t = 0; t < 300 && done !== 1 && err !== 1; t++) @(negedge clk);
	endtask
	function automatic string bits(input [3:0] n, input [63:0] a);
		string s = "";
		for (int i = 0; i < n; i++)
			s = {s, pin[a[8*i+4+:4]*8+a[8*i+:3]] ? "+1.000E+0" : "+0.000E+0",
				i < n - 1 ? "," : "\n"};
		return s;
	endfunction
	task word_test(input [1:0] s, input [7:0] w);
		pin[8*s+:8] = w;
		run(2'h1, s, 0, 0);
		chk_b(done);
		chk_b(rdy);
		chk_s(host_u.text, $sformatf("%03d\n", w));
	endtask
	task list_test(input [3:0] n, input [63:0] a);
		run(2'h2, 0, n, a);
		chk_s(host_u.text, bits(n, a));
	endtask
	task bad_test(input [63:0] a);
		run(2'h2, 0, 2, a);
		chk_b(err);
		chk_s(host_u.text, "");
	endtask
	task trig_test;
		ev = 3'h1;
		@(negedge clk);
		pin[0] = 1;
		repeat (4) @(negedge clk);
		chk_b(saw);
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1;
		word_test(1, 0);
		word_test(1, 173);
		slow = 1;
		word_test(2, 255);
		list_test(5, 64'h10_1113_1517);
		slow = 0;
		list_test(8, 64'h2726_2524_2322_2120);
		list_test(2, 64'h0700);
		bad_test(64'h1811);
		bad_test(64'h2920);
		bad_test(64'h0130);
		trig_test;
		give_verdict;
	end
endmodule // digital_input_port_read_tb
